// ==== logic/rdp_cfg.svh ====
// Constants for the dual-port memory core: geometry, register map, fields.
// Assumes inclusion by bare name from the core, the user model and the checker.
`ifndef RDP_CFG_SVH
`define RDP_CFG_SVH

// Geometry (logic variant flattens everything into one array)
`define RDP_VARIANT_LOGIC 0
`define RDP_WIDTH 8
`define RDP_DEPTH 96
`define RDP_AW 7
`define RDP_CELL_WORDS_HARD 32
`define RDP_CELL_BITS_HARD 8
`define RDP_CELL_WORDS ((`RDP_VARIANT_LOGIC != 0) ? `RDP_DEPTH : `RDP_CELL_WORDS_HARD)
`define RDP_CELL_BITS ((`RDP_VARIANT_LOGIC != 0) ? `RDP_WIDTH : `RDP_CELL_BITS_HARD)
`define RDP_CAW ((`RDP_VARIANT_LOGIC != 0) ? `RDP_AW : 5)
`define RDP_ROWS ((`RDP_DEPTH + `RDP_CELL_WORDS - 1) / `RDP_CELL_WORDS)
`define RDP_COLS (`RDP_WIDTH / `RDP_CELL_BITS)
`define RDP_NCELL (`RDP_ROWS * `RDP_COLS)

// APB map, byte addresses
`define RDP_PAW 12
`define RDP_OFS_CTRL 12'h000
`define RDP_OFS_WCOUNT 12'h004
`define RDP_OFS_RCOUNT 12'h008
`define RDP_OFS_LASTW 12'h00C

// Control register fields and reset value
`define RDP_CTRL_W 6
`define RDP_CTRL_WFALL 0
`define RDP_CTRL_RMODE_LO 1
`define RDP_CTRL_WE_USED 3
`define RDP_CTRL_RE_USED 4
`define RDP_CTRL_MANUAL 5
`define RDP_CTRL_RESET 6'h18
`define RDP_CNT_W 16

`endif

// ==== logic/rdp_pkg.sv ====
// Types shared by the dual-port memory core.
// Assumes rdp_cfg.svh sits in the include path.
package rdp_pkg;
  // Read port timing: clocked on an edge, or following the address
  typedef enum logic [1:0] {
    RDP_RD_RISE,
    RDP_RD_FALL,
    RDP_RD_NONE
  } rdp_rmode_t;

  // How per-cell control copies are sourced
  typedef enum logic {
    RDP_BUF_AUTO,
    RDP_BUF_MANUAL
  } rdp_buf_t;
endpackage : rdp_pkg

// ==== logic/rdp_cell.sv ====
// One memory cell: a write port and a registered read port on pclk.
// Assumes the caller decodes its row and qualifies both strobes.
`timescale 1ns/1ps
`default_nettype none
module rdp_cell #(
  parameter int WORDS = 32,
  parameter int BITS = 8,
  parameter int CAW = 5
) (
  input wire logic pclk,
  input wire logic wr_en,
  input wire logic [CAW-1:0] wr_addr,
  input wire logic [BITS-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [CAW-1:0] rd_addr,
  output logic [BITS-1:0] rd_data
);
  // Storage has no reset, like the cells it stands for
  logic [BITS-1:0] mem [WORDS];

  // Write port
  always_ff @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Read port, data from a register
  always_ff @(posedge pclk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : rdp_cell
`default_nettype wire

// ==== logic/rdp_core.sv ====
// Dual-port memory core with an APB control slave, built from tiled cells.
// Assumes user port pins are asynchronous to pclk and held >= 3 pclk around
// each write or read clock edge; all pins pass a two-stage synchroniser.
//
// Operation
// - Registered reads and writes run independently; both may complete together.
// - Write stores data at write address on the selected write clock edge.
// - Registered read loads output from read address on selected read edge.
// - Combinational mode: output follows read address contents, no read clock.
// - Write enable is active high and qualifies writes, or is unused.
// - Read enable is active high and qualifies reads, or is unused.
// - Read edge choice is rising, falling, or none for combinational reads.
// - Word length and depth are parameters; each constrains the other.
// - Hard variant tiles 32x8 or 64x4 dual-port cells to size; the cell address is fixed at 5 bits, so only 32-word cells are fully addressed.
// - Automatic buffering is the default, broadcasting controls to all cells.
// - Manual buffering gives each cell its own single-load copy of signals.
// - Manual buses are as wide as the number of cells each signal drives.
// - 96x8 from three 32x8 cells: enables and addresses reach every cell.
// - 128x8 from four 64x4 cells: data splits into independent 4-bit halves.
// - Logic variant gives identical behaviour from plain flip-flops.
//
// The register offsets and the APB slave port were left to the implementer.
`include "rdp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module rdp_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RDP_PAW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic write_port_clock,
  input wire logic write_enable,
  input wire logic [`RDP_AW-1:0] write_location,
  input wire logic [`RDP_WIDTH-1:0] write_data,
  input wire logic read_port_clock,
  input wire logic read_request,
  input wire logic [`RDP_AW-1:0] read_location,
  output logic [`RDP_WIDTH-1:0] read_data,
  input wire logic [`RDP_NCELL-1:0] write_enable_cell,
  input wire logic [`RDP_NCELL*`RDP_AW-1:0] write_location_cell,
  input wire logic [`RDP_ROWS*`RDP_WIDTH-1:0] write_data_cell,
  input wire logic [`RDP_NCELL-1:0] read_request_cell,
  input wire logic [`RDP_NCELL*`RDP_AW-1:0] read_location_cell
);
  localparam int W = `RDP_WIDTH;
  localparam int D = `RDP_DEPTH;
  localparam int AW = `RDP_AW;
  localparam int CW = `RDP_CELL_WORDS;
  localparam int CB = `RDP_CELL_BITS;
  localparam int CAW = `RDP_CAW;
  localparam int ROWS = `RDP_ROWS;
  localparam int COLS = `RDP_COLS;
  localparam int NC = `RDP_NCELL;
  localparam int CNT = `RDP_CNT_W;
  localparam int WB = 2 + AW + W + NC + NC * AW + ROWS * W;
  localparam int RB = 2 + AW + NC + NC * AW;

  logic [`RDP_CTRL_W-1:0] ctrl_r;
  logic [CNT-1:0] wcount_r;
  logic [CNT-1:0] rcount_r;
  logic [AW-1:0] lastw_r;
  logic [31:0] prdata_r;
  logic err_r;

  // Decode read-mode code; code 3 is not defined and falls back to rising
  function automatic rdp_pkg::rdp_rmode_t rd_mode_of(input logic [1:0] code);
    rdp_pkg::rdp_rmode_t m;
    unique case (code)
      2'h0: m = rdp_pkg::RDP_RD_RISE;
      2'h1: m = rdp_pkg::RDP_RD_FALL;
      2'h2: m = rdp_pkg::RDP_RD_NONE;
      default: m = rdp_pkg::RDP_RD_RISE;
    endcase
    return m;
  endfunction : rd_mode_of

  rdp_pkg::rdp_rmode_t rmode;
  rdp_pkg::rdp_buf_t bufmode;
  logic wfall;
  logic we_used;
  logic re_used;

  // Control fields steering the datapath
  assign rmode = rd_mode_of(ctrl_r[`RDP_CTRL_RMODE_LO+:2]);
  assign bufmode = ctrl_r[`RDP_CTRL_MANUAL] ? rdp_pkg::RDP_BUF_MANUAL : rdp_pkg::RDP_BUF_AUTO;
  assign wfall = ctrl_r[`RDP_CTRL_WFALL];
  assign we_used = ctrl_r[`RDP_CTRL_WE_USED];
  assign re_used = ctrl_r[`RDP_CTRL_RE_USED];

  // Pin synchronisers: write and read bundles each pass two stages together
  logic [WB-1:0] wpin;
  logic [WB-1:0] ws1_r;
  logic [WB-1:0] ws2_r;
  logic [RB-1:0] rpin;
  logic [RB-1:0] rs1_r;
  logic [RB-1:0] rs2_r;

  assign wpin = {write_port_clock, write_enable, write_location, write_data,
                 write_enable_cell, write_location_cell, write_data_cell};
  assign rpin = {read_port_clock, read_request, read_location,
                 read_request_cell, read_location_cell};

  // Two flops per bit; stage one feeds only stage two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ws1_r <= '0;
      ws2_r <= '0;
      rs1_r <= '0;
      rs2_r <= '0;
    end else begin
      ws1_r <= wpin;
      ws2_r <= ws1_r;
      rs1_r <= rpin;
      rs2_r <= rs1_r;
    end
  end

  logic wclk_s;
  logic we_s;
  logic [AW-1:0] wloc_s;
  logic [W-1:0] wdata_s;
  logic [NC-1:0] we_cell_s;
  logic [NC*AW-1:0] wloc_cell_s;
  logic [ROWS*W-1:0] wdata_cell_s;
  logic rclk_s;
  logic re_s;
  logic [AW-1:0] rloc_s;
  logic [NC-1:0] re_cell_s;
  logic [NC*AW-1:0] rloc_cell_s;

  assign {wclk_s, we_s, wloc_s, wdata_s, we_cell_s, wloc_cell_s, wdata_cell_s} = ws2_r;
  assign {rclk_s, re_s, rloc_s, re_cell_s, rloc_cell_s} = rs2_r;

  // Previous level of each synchronised clock for edge detection
  logic wclk_d_r;
  logic rclk_d_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wclk_d_r <= 1'b0;
      rclk_d_r <= 1'b0;
    end else begin
      wclk_d_r <= wclk_s;
      rclk_d_r <= rclk_s;
    end
  end

  logic wedge;
  logic redge;

  assign wedge = wfall ? (wclk_d_r & ~wclk_s) : (wclk_s & ~wclk_d_r);

  always_comb begin
    redge = 1'b0;
    unique case (rmode)
      rdp_pkg::RDP_RD_RISE: redge = rclk_s & ~rclk_d_r;
      rdp_pkg::RDP_RD_FALL: redge = rclk_d_r & ~rclk_s;
      rdp_pkg::RDP_RD_NONE: redge = 1'b1;
    endcase
  end

  logic [NC-1:0] wr_vec;
  logic [NC-1:0] rd_go_vec;
  logic [NC-1:0] rd_hit_vec;
  logic [NC-1:0] hit_r;
  logic [CB-1:0] cell_q [NC];
  logic [AW-1:0] wa_eff;

  // Address recorded as last written: broadcast or copy of cell 0
  assign wa_eff = (bufmode == rdp_pkg::RDP_BUF_MANUAL) ? wloc_cell_s[AW-1:0] : wloc_s;

  // tile rows of cells over depth, columns over width
  for (genvar r = 0; r < ROWS; r++) begin : g_row
    for (genvar c = 0; c < COLS; c++) begin : g_col
      localparam int K = r * COLS + c;
      localparam logic [AW:0] LO = (AW + 1)'(r * CW);
      localparam logic [AW:0] HI = (AW + 1)'(((r + 1) * CW < D) ? (r + 1) * CW : D);
      logic we_k;
      logic re_k;
      logic [AW-1:0] wa_k;
      logic [AW-1:0] ra_k;
      logic [CB-1:0] wd_k;
      logic [AW:0] wsub;
      logic [AW:0] rsub;
      logic whit;
      logic rhit;

      // automatic mode broadcasts one net to all cells
      // manual mode takes this cell's own copy
      // enables and addresses reach every cell
      assign we_k = (bufmode == rdp_pkg::RDP_BUF_MANUAL) ? we_cell_s[K] : we_s;
      assign re_k = (bufmode == rdp_pkg::RDP_BUF_MANUAL) ? re_cell_s[K] : re_s;
      assign wa_k = (bufmode == rdp_pkg::RDP_BUF_MANUAL) ? wloc_cell_s[K*AW+:AW] : wloc_s;
      assign ra_k = (bufmode == rdp_pkg::RDP_BUF_MANUAL) ? rloc_cell_s[K*AW+:AW] : rloc_s;

      // one data copy per row of cells
      // each column slice is an independent data path
      assign wd_k = (bufmode == rdp_pkg::RDP_BUF_MANUAL) ?
                    wdata_cell_s[r*W + c*CB +: CB] : wdata_s[c*CB +: CB];

      // Row decode; addresses at or past depth hit no cell
      assign whit = ({1'b0, wa_k} >= LO) && ({1'b0, wa_k} < HI);
      assign rhit = ({1'b0, ra_k} >= LO) && ({1'b0, ra_k} < HI);
      assign wsub = {1'b0, wa_k} - LO;
      assign rsub = {1'b0, ra_k} - LO;

      assign wr_vec[K] = wedge & (~we_used | we_k) & whit;

      assign rd_go_vec[K] = redge & (~re_used | re_k);
      assign rd_hit_vec[K] = rd_go_vec[K] & rhit;

      // separate write and read ports per cell
      // same cell model serves the flat logic variant
      rdp_cell #(
        .WORDS(CW),
        .BITS(CB),
        .CAW(CAW)
      ) u_cell (
        .pclk(pclk),
        .wr_en(wr_vec[K]),
        .wr_addr(wsub[CAW-1:0]),
        .wr_data(wd_k),
        .rd_en(rd_hit_vec[K]),
        .rd_addr(rsub[CAW-1:0]),
        .rd_data(cell_q[K])
      );
    end
  end

  // Which cells delivered data, and whether any read was taken
  logic rd_load_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hit_r <= '0;
      rd_load_r <= 1'b0;
    end else begin
      if (|rd_go_vec) begin
        hit_r <= rd_hit_vec;
      end
      rd_load_r <= |rd_go_vec;
    end
  end

  // Merge the hit row's cells into one word; a miss gives zero
  logic [W-1:0] rd_word;

  always_comb begin
    rd_word = '0;
    for (int k = 0; k < NC; k++) begin
      if (hit_r[k]) begin
        rd_word[(k % COLS)*CB +: CB] = rd_word[(k % COLS)*CB +: CB] | cell_q[k];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_data <= '0;
    end else if (rd_load_r) begin
      read_data <= rd_word;
    end
  end

  // Activity counters and last written address for software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wcount_r <= '0;
      lastw_r <= '0;
    end else if (|wr_vec) begin
      wcount_r <= wcount_r + 1'b1;
      lastw_r <= wa_eff;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rcount_r <= '0;
    end else if (rd_load_r) begin
      rcount_r <= rcount_r + 1'b1;
    end
  end

  // APB: read data and error prepared in setup, shown in access
  logic setup;
  logic access;
  logic mapped;
  logic [31:0] rd_mux;

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign pready = 1'b1; // Zero wait states
  assign pslverr = access & err_r;
  assign prdata = prdata_r;

  always_comb begin
    mapped = 1'b1;
    rd_mux = '0;
    unique case (paddr)
      `RDP_OFS_CTRL: rd_mux = {{(32 - `RDP_CTRL_W){1'b0}}, ctrl_r};
      `RDP_OFS_WCOUNT: rd_mux = {{(32 - CNT){1'b0}}, wcount_r};
      `RDP_OFS_RCOUNT: rd_mux = {{(32 - CNT){1'b0}}, rcount_r};
      `RDP_OFS_LASTW: rd_mux = {{(32 - AW){1'b0}}, lastw_r};
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      err_r <= 1'b0;
    end else if (setup) begin
      prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
      err_r <= ~mapped;
    end
  end

  // Control register write; other offsets are read-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= `RDP_CTRL_RESET;
    end else if (access && pwrite && paddr == `RDP_OFS_CTRL) begin
      ctrl_r <= pwdata[`RDP_CTRL_W-1:0];
    end
  end
endmodule : rdp_core
`default_nettype wire

// ==== verif/rdp_user_model.sv ====
// User logic driving the write and read ports of the memory core.
// Assumes pclk from the bench; pins held 4 pclk around each edge.
`include "rdp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module rdp_user_model (
  input wire logic pclk,
  output logic write_port_clock,
  output logic write_enable,
  output logic [`RDP_AW-1:0] write_location,
  output logic [`RDP_WIDTH-1:0] write_data,
  output logic read_port_clock,
  output logic read_request,
  output logic [`RDP_AW-1:0] read_location,
  output logic [`RDP_NCELL-1:0] write_enable_cell,
  output logic [`RDP_NCELL*`RDP_AW-1:0] write_location_cell,
  output logic [`RDP_ROWS*`RDP_WIDTH-1:0] write_data_cell,
  output logic [`RDP_NCELL-1:0] read_request_cell,
  output logic [`RDP_NCELL*`RDP_AW-1:0] read_location_cell
);
  assign write_enable_cell = {`RDP_NCELL{write_enable}};
  assign write_location_cell = {`RDP_NCELL{write_location}};
  assign write_data_cell = {`RDP_ROWS{write_data}};
  assign read_request_cell = {`RDP_NCELL{read_request}};
  assign read_location_cell = {`RDP_NCELL{read_location}};

  // Quiet pins at time zero
  initial begin
    write_port_clock = 1'b0;
    write_enable = 1'b0;
    write_location = 7'h00;
    write_data = 8'h00;
    read_port_clock = 1'b0;
    read_request = 1'b0;
    read_location = 7'h00;
  end

  task automatic gap();
    repeat (4) @(posedge pclk);
  endtask : gap

  // reads parked off the written word
  task automatic wr(input logic [6:0] a, input logic [7:0] dr, input logic [7:0] df, input logic en);
    read_location <= 7'h7F;
    write_location <= a;
    write_data <= dr;
    write_enable <= en;
    gap();
    write_port_clock <= 1'b1;
    gap();
    write_data <= df;
    gap();
    write_port_clock <= 1'b0;
    gap();
    write_data <= ~df; // Hold over, show a stale pattern
    write_enable <= 1'b0;
    // Let an edge pass so a following call never reassigns in this step
    gap();
  endtask : wr

  task automatic rd(input logic [6:0] ar, input logic [6:0] af, input logic rq);
    read_location <= ar;
    read_request <= rq;
    gap();
    read_port_clock <= 1'b1;
    gap();
    read_location <= af;
    gap();
    read_port_clock <= 1'b0;
    gap();
  endtask : rd
endmodule : rdp_user_model
`default_nettype wire

// ==== verif/rdp_core_assertions.sv ====
// Checker for the memory core: bus answers and output timing.
// Assumes binding into rdp_core; one pclk domain.
`include "rdp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module rdp_core_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`RDP_PAW-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic write_port_clock,
  input wire logic read_port_clock,
  input wire logic read_request,
  input wire logic [`RDP_AW-1:0] read_location,
  input wire logic [`RDP_WIDTH-1:0] read_data
);
  logic [3:0] quiet_r;
  logic acc;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  assign acc = psel && penable;
  // Cycles since a pin moved; output may only move shortly after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quiet_r <= 4'h0;
    end else if ($changed({write_port_clock, read_port_clock, read_request, read_location, psel})) begin
      quiet_r <= 4'h0;
    end else if (quiet_r != 4'hF) begin
      quiet_r <= quiet_r + 4'h1;
    end
  end
  a_ready_zero_wait: assert property (psel && !penable |=> pready)
    else $error("no ready in access");
  a_err_unmapped: assert property (acc && paddr > 12'h00C |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_err_mapped_ok: assert property (acc && paddr inside {12'h000, 12'h004, 12'h008, 12'h00C} |-> !pslverr)
    else $error("mapped access refused");
  a_err_only_access: assert property (pslverr |-> acc)
    else $error("error outside access");
  a_prdata_setup: assert property ($changed(prdata) |-> $past(psel && !penable))
    else $error("read data moved outside setup");
  a_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_ctrl_narrow: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata[31:6] == 26'h0)
    else $error("control readback too wide");
  a_rdata_quiet: assert property ($changed(read_data) |-> quiet_r < 4'hC)
    else $error("output moved without cause");
  c_refused: cover property (acc && pslverr);
  c_out_moved: cover property ($changed(read_data));
  c_ctrl_write: cover property (acc && pwrite && paddr == 12'h000);
endmodule : rdp_core_chk
bind rdp_core rdp_core_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .write_port_clock, .read_port_clock, .read_request, .read_location, .read_data);
`default_nettype wire

// ==== verif/test_dual_port_ram_sync_async_read.sv ====
// Bench for the memory core: bus setup, both ports, every read mode.
// Assumes the user model and the checker compile beside it.
`timescale 1ns/1ps
`default_nettype none
module test_dual_port_ram_sync_async_read;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic write_port_clock, write_enable, read_port_clock, read_request;
  logic [6:0] write_location, read_location;
  logic [7:0] write_data, read_data;
  logic [2:0] write_enable_cell, read_request_cell;
  logic [20:0] write_location_cell, read_location_cell;
  logic [23:0] write_data_cell;
  logic [7:0] exp_mem [0:95];
  logic [6:0] locs [4] = '{7'h00, 7'h1F, 7'h20, 7'h5F}; // Cell edges
  logic [5:0] cfgs [5] = '{6'h18, 6'h1B, 6'h1D, 6'h1E, 6'h38};
  int n_errors, num_checks;

  // 100 MHz clock
  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  rdp_core uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .write_port_clock, .write_enable, .write_location, .write_data, .read_port_clock, .read_request,
    .read_location, .read_data, .write_enable_cell, .write_location_cell, .write_data_cell,
    .read_request_cell, .read_location_cell);
  rdp_user_model user (.pclk, .write_port_clock, .write_enable, .write_location, .write_data,
    .read_port_clock, .read_request, .read_location, .write_enable_cell, .write_location_cell,
    .write_data_cell, .read_request_cell, .read_location_cell);

  task automatic final_report();
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] want);
    num_checks++;
    if (got !== want) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : chk

  // One transfer; answer taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic setc(input logic [5:0] c);
    apb(1'b1, 12'h000, {26'h0, c});
    apb(1'b0, 12'h000, 32'h0);
    chk(q, {26'h0, c});
  endtask : setc

  task automatic t_reset();
    chk({24'h0, read_data}, 32'h0);
    apb(1'b0, 12'h000, 32'h0);
    chk(q, 32'h18);
    apb(1'b0, 12'h010, 32'h0);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, 12'h004, 32'hFFFF);
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h0);
  endtask : t_reset

  task automatic t_enables();
    setc(6'h18);
    user.wr(7'h05, 8'h3C, 8'hC3, 1'b1);
    user.wr(7'h05, 8'h99, 8'h66, 1'b0);
    user.rd(7'h05, 7'h05, 1'b1);
    repeat (8) @(posedge pclk);
    chk({24'h0, read_data}, 32'h3C);
    user.rd(7'h00, 7'h00, 1'b0);
    repeat (8) @(posedge pclk);
    chk({24'h0, read_data}, 32'h3C);
    setc(6'h00);
    user.wr(7'h05, 8'h77, 8'h88, 1'b0);
    user.rd(7'h05, 7'h05, 1'b0);
    repeat (8) @(posedge pclk);
    chk({24'h0, read_data}, 32'h77);
    apb(1'b0, 12'h004, 32'h0);
    chk(q, 32'h2);
    apb(1'b0, 12'h00C, 32'h0);
    chk(q, 32'h5);
    apb(1'b0, 12'h008, 32'h0);
    chk(q, 32'h2);
  endtask : t_enables

  // Writes then reads at cell edges; rise data differs from fall data
  task automatic t_access(input logic [5:0] c);
    logic [6:0] a;
    logic [7:0] d;
    setc(c);
    for (int k = 0; k < 4; k++) begin
      a = locs[k];
      d = {1'b0, a} ^ {2'b00, c};
      user.wr(a, d, ~d, 1'b1);
      exp_mem[a] = c[0] ? ~d : d;
    end
    for (int k = 0; k < 4; k++) begin
      user.rd(locs[k], locs[3 - k], 1'b1);
      repeat (8) @(posedge pclk);
      a = (c[2:1] == 2'b01 || c[2:1] == 2'b10) ? locs[3 - k] : locs[k];
      chk({24'h0, read_data}, {24'h0, exp_mem[a]});
    end
  endtask : t_access

  // Main sequence
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    presetn = 1'b0;
    n_errors = 0;
    num_checks = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_enables();
    foreach (cfgs[i]) t_access(cfgs[i]);
    final_report();
  end

  // Watchdog well beyond the expected run
  initial begin
    #300us;
    n_errors++;
    final_report();
  end
endmodule : test_dual_port_ram_sync_async_read
`default_nettype wire
